// >>> pstl_map.svh
// constants for the port skip and timer 1 load execution block
// assumes the core decoder presents one instruction word per taken cycle
`ifndef PSTL_MAP_SVH
`define PSTL_MAP_SVH
// ----------------------------------------
// opcodes
// ----------------------------------------
`define PSTL_OP_SKIP_W1  10'h024
`define PSTL_OP_SKIP_W2  10'h02b
`define PSTL_OP_TLOAD    10'h230
// ----------------------------------------
// field layout and reset values
// ----------------------------------------
`define PSTL_NIB_W       4
`define PSTL_PTR_MAX     4'h3
`define PSTL_TMR_RST     8'h00
`define PSTL_SEL_MSB     1
`define PSTL_HI_MSB      7
`define PSTL_HI_LSB      4
`define PSTL_LO_MSB      3
`define PSTL_LO_LSB      0
`endif

// >>> pstl_pkg.sv
// types for the port skip and timer 1 load execution block
// assumes pstl_map.svh supplies the numeric constants
package pstl_pkg;
   typedef enum logic [1:0] {
      PSTL_ST_IDLE   = 2'b01,
      PSTL_ST_SECOND = 2'b10
   } pstl_state_e;
   typedef logic [3:0] pstl_nib_t;
   typedef logic [7:0] pstl_byte_t;
endpackage

// >>> pstl_bit_select.sv
// picks one port bit by the bit pointer and flags an out-of-range pointer
// assumes a four-bit port and a four-bit pointer
`include "pstl_map.svh"
module pstl_bit_select
   import pstl_pkg::*;
#(
   parameter int PORT_W = 4
) (
   input  wire logic [PORT_W-1:0] i_port,
   input  wire logic [3:0]        i_ptr,
   output logic                   o_in_range,
   output logic                   o_bit
);
   always_comb begin
      o_in_range = (i_ptr <= `PSTL_PTR_MAX);
      o_bit      = 1'b1;
      if (o_in_range) begin
         o_bit = i_port[i_ptr[`PSTL_SEL_MSB:0]];
      end
   end
endmodule

// >>> pstl_exec.sv
// execution of the two-word port bit skip and the timer 1 load
// assumes i_exec marks each instruction word taken; inputs sync to i_clk
// assumes the core itself drops the word after a raised o_skip_next
// holds no memory beyond the timer bytes, the one waiting state of the skip op and the one-cycle skip, load and carry flops
`include "pstl_map.svh"
module pstl_exec
   import pstl_pkg::*;
#(
   parameter int PORT_W = 4
) (
   input  wire logic              i_clk,
   input  wire logic              i_rst,
   input  wire logic              i_exec,
   input  wire logic [9:0]        i_opcode,
   input  wire logic [PORT_W-1:0] i_port,
   input  wire logic [3:0]        i_bit_ptr,
   input  wire logic [3:0]        i_upper,
   input  wire logic [3:0]        i_acc,
   input  wire logic              i_carry,
   output logic                   o_skip_next,
   output logic                   o_busy,
   output logic                   o_timer_load,
   output logic [7:0]             o_timer_count,
   output logic [7:0]             o_timer_reload,
   output logic                   o_carry
);
   // ----------------------------------------
   // decode
   // ----------------------------------------
   // one compare helper so every opcode match reads alike
   function automatic logic is_op(input logic [9:0] op, input logic [9:0] code);
      is_op = (op == code);
   endfunction

   pstl_state_e state;
   pstl_state_e next_state;
   logic        next_skip_next;
   logic        next_timer_load;
   pstl_byte_t  next_timer_count;
   pstl_byte_t  next_timer_reload;
   logic        next_carry;
   logic        ptr_ok;
   logic        sel_bit;
   logic        tload;
   logic        skip_w1;
   logic        skip_w2;

   pstl_bit_select #(
      .PORT_W (PORT_W)
   ) u_sel (
      .i_port     (i_port),
      .i_ptr      (i_bit_ptr),
      .o_in_range (ptr_ok),
      .o_bit      (sel_bit)
   );

   // the words are told apart only by their code; i_exec gates all three
   assign tload   = i_exec && is_op(i_opcode, `PSTL_OP_TLOAD);
   assign skip_w1 = i_exec && is_op(i_opcode, `PSTL_OP_SKIP_W1);
   assign skip_w2 = i_exec && is_op(i_opcode, `PSTL_OP_SKIP_W2);
   assign o_busy  = (state == PSTL_ST_SECOND);

   // ----------------------------------------
   // skip sequencer
   // ----------------------------------------
   // the port bit is sampled with the second word, not the first, so a pin
   // that settles during the first word is still seen at its final level
   always_comb begin
      next_state     = state;
      next_skip_next = 1'b0;
      case (state)
         PSTL_ST_IDLE: begin
            if (skip_w1) begin
               next_state = PSTL_ST_SECOND;
            end
         end
         PSTL_ST_SECOND: begin
            // any word taken here ends the op; only the partner code may skip
            if (i_exec) begin
               next_state = PSTL_ST_IDLE;
               if (skip_w2) begin
                  next_skip_next = ptr_ok && !sel_bit;
               end
            end
         end
         default: begin
            next_state = PSTL_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state       <= PSTL_ST_IDLE;
         o_skip_next <= 1'b0;
      end
      else begin
         state       <= next_state;
         o_skip_next <= next_skip_next;
      end
   end

   // ----------------------------------------
   // timer 1 count and reload
   // ----------------------------------------
   // a load word that arrives while a skip waits for its second word is
   // consumed as that second word and loads nothing
   always_comb begin
      next_timer_load   = 1'b0;
      next_timer_count  = o_timer_count;
      next_timer_reload = o_timer_reload;
      if (tload && (state == PSTL_ST_IDLE)) begin
         // count and reload take the same byte in one cycle
         next_timer_load   = 1'b1;
         next_timer_count  = {i_upper, i_acc};
         next_timer_reload = {i_upper, i_acc};
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_timer_load   <= 1'b0;
         o_timer_count  <= `PSTL_TMR_RST;
         o_timer_reload <= `PSTL_TMR_RST;
      end
      else begin
         o_timer_load   <= next_timer_load;
         o_timer_count  <= next_timer_count;
         o_timer_reload <= next_timer_reload;
      end
   end

   // ----------------------------------------
   // carry
   // ----------------------------------------
   // neither op writes the carry; it is passed on a cycle late so that the
   // core sees it aligned with the other registered results
   always_comb begin
      next_carry = i_carry;
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_carry <= 1'b0;
      end
      else begin
         o_carry <= next_carry;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   // ----------------------------------------
   // checks on the skip op
   // ----------------------------------------
   a_skip_on_zero: assert property (
      (o_busy && i_exec && i_opcode == `PSTL_OP_SKIP_W2 && i_bit_ptr <= `PSTL_PTR_MAX
       && !i_port[i_bit_ptr[`PSTL_SEL_MSB:0]]) |=> o_skip_next)
      else $error("port bit zero did not skip");
   a_run_on_one: assert property (
      (o_busy && i_exec && i_bit_ptr <= `PSTL_PTR_MAX && i_port[i_bit_ptr[`PSTL_SEL_MSB:0]])
      |=> !o_skip_next)
      else $error("port bit one skipped");
   a_bad_ptr_nop: assert property (
      (o_busy && i_bit_ptr > `PSTL_PTR_MAX) |=> !o_skip_next)
      else $error("out of range pointer skipped");
   a_bad_word_nop: assert property (
      (o_busy && i_exec && i_opcode != `PSTL_OP_SKIP_W2) |=> !o_skip_next)
      else $error("skip taken on a foreign second word");
   a_busy_on_first: assert property (
      (!o_busy && i_exec && i_opcode == `PSTL_OP_SKIP_W1) |=> o_busy)
      else $error("first skip word did not wait for the second");
   a_busy_ends: assert property (
      (o_busy && i_exec) |=> !o_busy)
      else $error("skip op did not end on its second word");
   // a stray skip silently drops an instruction, so every skip must trace back
   // to an in range second word of this op
   a_skip_cause: assert property (
      o_skip_next |-> ($past(o_busy) && $past(i_exec)
                       && $past(i_opcode) == `PSTL_OP_SKIP_W2
                       && $past(i_bit_ptr) <= `PSTL_PTR_MAX))
      else $error("skip without an in range second word");
   a_skip_one_cycle: assert property (
      o_skip_next |=> !o_skip_next)
      else $error("skip request held longer than one cycle");
   a_idle_noskip: assert property (
      !o_busy |=> !o_skip_next)
      else $error("skip raised outside a skip op");

   // ----------------------------------------
   // checks on the timer load and carry
   // ----------------------------------------
   a_tload_one_cycle: assert property (
      (!o_busy && i_exec && i_opcode == `PSTL_OP_TLOAD) |=> o_timer_load)
      else $error("timer load not done in one cycle");
   // a pulse with no load word in front of it would reload the timer twice
   a_tload_only: assert property (
      !(!o_busy && i_exec && i_opcode == `PSTL_OP_TLOAD) |=> !o_timer_load)
      else $error("timer loaded without a load word");
   a_tload_high: assert property (
      o_timer_load |-> (o_timer_count[`PSTL_HI_MSB:`PSTL_HI_LSB] == $past(i_upper)
                        && o_timer_reload[`PSTL_HI_MSB:`PSTL_HI_LSB] == $past(i_upper)))
      else $error("timer high nibble wrong");
   a_tload_low: assert property (
      o_timer_load |-> (o_timer_count[`PSTL_LO_MSB:`PSTL_LO_LSB] == $past(i_acc)
                        && o_timer_reload[`PSTL_LO_MSB:`PSTL_LO_LSB] == $past(i_acc)))
      else $error("timer low nibble wrong");
   a_tload_noskip: assert property (
      o_timer_load |-> (!o_skip_next && o_carry == $past(i_carry)))
      else $error("timer load skipped or touched carry");
   // count and reload may only move on a load; the core reads them between
   // loads and expects the value it wrote
   a_timer_hold: assert property (
      !o_timer_load |-> ($stable(o_timer_reload) && $stable(o_timer_count)))
      else $error("timer changed without a load");
   a_carry_kept: assert property (
      !$past(i_rst) |-> (o_carry == $past(i_carry)))
      else $error("carry changed by this block");
endmodule

// >>> pstl_exec_tb.sv
// self-checking bench for the port skip and timer 1 load execution block
// assumes pstl_exec at the top; inputs are driven by nba at the rising edge
module pstl_exec_tb
   import pstl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        i_clk = 1'h0, i_rst = 1'h1, i_exec = 1'h0, i_carry = 1'h0;
   logic [9:0]  i_opcode = 10'h000;
   logic [3:0]  i_port = 4'h0, i_bit_ptr = 4'h0, i_upper = 4'h0, i_acc = 4'h0;
   logic        o_skip_next, o_busy, o_timer_load, o_carry;
   pstl_byte_t  o_timer_count, o_timer_reload;
   logic [31:0] seed = 32'h25613aaa;
   logic [31:0] r;
   int          bad_count = 0, comparisons = 0, cycles = 0;
   // ----------------------------------------
   // clock, device and helpers
   // ----------------------------------------
   always #4 i_clk = ~i_clk;
   pstl_exec #(.PORT_W(4)) uut (.i_clk(i_clk), .i_rst(i_rst), .i_exec(i_exec),
      .i_opcode(i_opcode), .i_port(i_port), .i_bit_ptr(i_bit_ptr), .i_upper(i_upper),
      .i_acc(i_acc), .i_carry(i_carry), .o_skip_next(o_skip_next), .o_busy(o_busy),
      .o_timer_load(o_timer_load), .o_timer_count(o_timer_count),
      .o_timer_reload(o_timer_reload), .o_carry(o_carry));
   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // a wrong second word cancels the skip, so it counts as no skip
   function automatic logic exp_skip(input logic [9:0] w2, input logic [3:0] port, ptr);
      return (w2 == 10'h02b) && (ptr <= 4'h3) && !port[ptr[1:0]];
   endfunction
   task automatic wrap_up();
      $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk1(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk8(input pstl_byte_t got, input pstl_byte_t exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // ----------------------------------------
   // operations
   // ----------------------------------------
   // port is flipped after the second word so a late sample is caught
   task automatic skip_op(input logic [9:0] w2, input logic [3:0] port, ptr);
      @(posedge i_clk) i_exec <= 1'h1;
      i_opcode <= 10'h024;
      @(posedge i_clk) i_opcode <= w2;
      i_port <= port;
      i_bit_ptr <= ptr;
      #1 chk1(o_busy, 1'h1);
      @(posedge i_clk) i_exec <= 1'h0;
      i_port <= ~port;
      #1 chk1(o_skip_next, exp_skip(w2, port, ptr));
      chk1(o_timer_load, 1'h0);
      @(posedge i_clk) #1 chk1(o_skip_next, 1'h0);
   endtask
   task automatic tload(input logic [3:0] up, ac, input logic cy);
      @(posedge i_clk) i_exec <= 1'h1;
      i_opcode <= 10'h230;
      i_upper <= up;
      i_acc <= ac;
      i_carry <= cy;
      @(posedge i_clk) i_exec <= 1'h0;
      i_upper <= ~up;
      i_acc <= ~ac;
      i_carry <= ~cy;
      #1 chk1(o_timer_load, 1'h1);
      chk8(o_timer_count, {up, ac});
      chk8(o_timer_reload, {up, ac});
      chk1(o_skip_next, 1'h0);
      chk1(o_carry, cy);
      @(posedge i_clk) #1 chk1(o_timer_load, 1'h0);
      chk8(o_timer_reload, {up, ac});
      chk8(o_timer_count, {up, ac});
      chk1(o_carry, ~cy);
   endtask
   // ----------------------------------------
   // sequence and hang guard
   // ----------------------------------------
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 3000) begin
         bad_count++;
         wrap_up();
      end
   end
   initial begin
      repeat (4) @(posedge i_clk);
      i_rst <= 1'h0;
      skip_op(10'h02b, 4'he, 4'h0);
      skip_op(10'h02b, 4'h8, 4'h3);
      skip_op(10'h02b, 4'h0, 4'h4);
      skip_op(10'h230, 4'h0, 4'h1);
      tload(4'hf, 4'h0, 1'h1);
      for (int k = 0; k < 300; k++) begin
         r = rnd();
         if (r[0])
            skip_op(10'h02b, r[7:4], r[11:8]);
         else
            tload(r[7:4], r[11:8], r[12]);
      end
      wrap_up();
   end
endmodule
